// >>> bench/pane_chk.sv
// Purpose: Port checks for the encoder
// Assumes: Bound to pane_encoder
// Notes:   Sync reset disables all but the reset check
`timescale 1ns/1ps
module pane_chk
  import pane_pkg::*;
(
  input wire logic       clk,            // Clock
  input wire logic       reset,          // Reset
  input wire logic       addr_sel_strap, // Strap
  input wire logic       port1_addr_wr,  // Write 1
  input wire logic       port2_addr_wr,  // Write 2
  input wire logic [4:0] addr_wr_data,   // Write value
  input wire logic [4:0] vphy_addr,      // Virtual address
  input wire logic [4:0] port1_addr,     // Port 1 address
  input wire logic [4:0] port2_addr,     // Port 2 address
  input wire logic       mii_tx_en,      // Enable
  input wire logic       mii_tx_er,      // Error
  input wire logic [3:0] mii_txd,        // Nibble
  input wire logic       mii_tx_ready,   // Ready
  input wire logic [4:0] cg_data,        // Group
  input wire logic       cg_valid,       // Valid
  input wire logic       cg_ready        // Taken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_reset_idle: assert property (disable iff (1'b0)
    reset |=> !cg_valid && cg_data == CG_IDLE)
    else $error("output not idle in reset");
  chk_idle_fill: assert property (!cg_valid |-> cg_data == CG_IDLE)
    else $error("no idle when empty");
  chk_stall_hold: assert property (cg_valid && !cg_ready |=>
    cg_valid && $stable(cg_data))
    else $error("group lost in stall");
  chk_strap_held: assert property (!$past(reset) && !$past(reset, 2) |->
    $stable(vphy_addr))
    else $error("strap address moved");
  chk_default_addr: assert property ($past(reset) |=> vphy_addr <= 5'h01 &&
    port1_addr == vphy_addr + 5'h01 && port2_addr == vphy_addr + 5'h02)
    else $error("default address wrong");
  chk_port1_load: assert property (port1_addr_wr |=>
    port1_addr == $past(addr_wr_data))
    else $error("port 1 address not loaded");
  chk_port2_load: assert property (port2_addr_wr |=>
    port2_addr == $past(addr_wr_data))
    else $error("port 2 address not loaded");
  chk_no_invalid: assert property (cg_valid |-> !(cg_data inside {
    5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h19}))
    else $error("invalid group sent");
  chk_j_then_k: assert property (cg_valid && cg_ready && cg_data == CG_J
    |=> !cg_valid || cg_data == CG_K)
    else $error("start pair broken");
  chk_t_then_r: assert property (cg_valid && cg_ready && cg_data == CG_T
    |=> !cg_valid || cg_data == CG_R)
    else $error("end pair broken");
  cov_start: cover property (cg_valid && cg_ready && cg_data == CG_J);
  cov_end: cover property (cg_valid && cg_ready && cg_data == CG_T);
  cov_stall: cover property (cg_valid && !cg_ready);
  cov_full: cover property (!mii_tx_ready);
endmodule : pane_chk
bind pane_encoder pane_chk u_chk (.clk(clk), .reset(reset), .addr_sel_strap(addr_sel_strap),
  .port1_addr_wr(port1_addr_wr), .port2_addr_wr(port2_addr_wr), .addr_wr_data(addr_wr_data),
  .vphy_addr(vphy_addr), .port1_addr(port1_addr), .port2_addr(port2_addr),
  .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er), .mii_txd(mii_txd),
  .mii_tx_ready(mii_tx_ready), .cg_data(cg_data), .cg_valid(cg_valid), .cg_ready(cg_ready));

// >>> bench/pane_encoder_tb.sv
// Purpose: Self-checking bench for the encoder
// Assumes: Groups other than idle checked in order
// Notes:   Expected groups queued by the driver
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module pane_encoder_tb;
  import pane_pkg::*;
  logic        clk = 0, reset = 1, strap = 0, w1 = 0, w2 = 0, en = 0, er = 0, hold = 0;
  logic        rdy, cv, cr;
  logic [4:0]  wd = 0, va, p1, p2, cg;
  logic [3:0]  txd = 0;
  logic [31:0] lf = 32'h727FD555;
  logic [4:0]  expq[$];
  int          n_fail = 0, cmp_count = 0;
  // Clock
  initial forever #12.5 clk = ~clk;
  pane_encoder dut (.clk(clk), .reset(reset), .addr_sel_strap(strap), .port1_addr_wr(w1),
    .port2_addr_wr(w2), .addr_wr_data(wd), .vphy_addr(va), .port1_addr(p1), .port2_addr(p2),
    .mii_tx_en(en), .mii_tx_er(er), .mii_txd(txd), .mii_tx_ready(rdy), .cg_data(cg),
    .cg_valid(cv), .cg_ready(cr));
  pane_sink u_sink (.clk(clk), .reset(reset), .hold(hold), .cg_valid(cv), .cg_ready(cr));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [4:0] enc(input logic [3:0] n);
    logic [4:0] t[16];
    t = '{CG_D0, CG_D1, CG_D2, CG_D3, CG_D4, CG_D5, CG_D6, CG_D7,
          CG_D8, CG_D9, CG_DA, CG_DB, CG_DC, CG_DD, CG_DE, CG_DF};
    return t[n];
  endfunction : enc
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // One MII cycle, held until taken
  task automatic step(input logic e, input logic r, input logic [3:0] d);
    int i;
    en <= e;
    er <= r;
    txd <= d;
    @(negedge clk);
    for (i = 0; rdy !== 1'b1; i++) begin
      if (i == 300) begin n_fail++; end_sim(); end
      @(negedge clk);
    end
    @(posedge clk);
  endtask : step
  task automatic frame(input int n, input bit rnd);
    int i;
    logic [3:0] d;
    expq.push_back(CG_J);
    step(1, 0, 4'h5);
    expq.push_back(CG_K);
    step(1, 0, 4'h5);
    for (i = 0; i < n; i++) begin
      d = rnd ? lf[3:0] : i[3:0];
      lf = nx(lf);
      expq.push_back(i == 3 ? CG_ERR : enc(d));
      step(1, i == 3, d);
    end
    expq.push_back(CG_T);
    step(0, 0, 4'h0);
    expq.push_back(CG_R);
    step(0, 0, 4'h0);
  endtask : frame
  task automatic drain();
    int i;
    for (i = 0; i < 400 && expq.size() != 0; i++) @(posedge clk);
    `CHK(expq.size(), 0)
    if (expq.size() != 0) end_sim();
  endtask : drain
  task automatic rst(input logic s);
    reset <= 1; strap <= s;
    repeat (20) @(posedge clk);
    reset <= 0;
    repeat (3) @(posedge clk);
    `CHK(va, s ? VPHY_ADDR_HIGH : VPHY_ADDR_LOW)
    `CHK(p1, s ? PORT1_ADDR_HIGH : PORT1_ADDR_LOW)
    `CHK(p2, s ? PORT2_ADDR_HIGH : PORT2_ADDR_LOW)
  endtask : rst
  logic [4:0]  exp_cg;
  // Compare each taken non-idle group with the oldest note, popped once
  always @(posedge clk) begin
    if (!reset && cv === 1'b1 && cr === 1'b1 && cg !== CG_IDLE) begin
      if (expq.size() == 0) begin
        `CHK(cg, CG_IDLE)
      end else begin
        exp_cg = expq.pop_front();
        `CHK(cg, exp_cg)
      end
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  // Main sequence
  initial begin
    rst(0);
    strap <= 1;
    repeat (4) @(posedge clk);
    `CHK(va, VPHY_ADDR_LOW)
    `CHK(p1, PORT1_ADDR_LOW)
    $display("test strap done");
    rst(1);
    frame(16, 0);
    frame(20, 1);
    drain();
    $display("test frames done");
    wd <= va;
    w1 <= 1;
    @(posedge clk);
    w1 <= 0;
    wd <= lf[4:0];
    w2 <= 1;
    @(posedge clk);
    w2 <= 0;
    @(negedge clk);
    `CHK(p1, va)
    `CHK(p2, lf[4:0])
    $display("test overrides done");
    @(posedge clk);
    hold <= 1;
    repeat (60) @(posedge clk);
    `CHK(rdy, 1'b0)
    hold <= 0;
    frame(4, 1);
    drain();
    reset <= 1;
    @(posedge clk);
    @(negedge clk);
    `CHK(cv, 1'b0)
    `CHK(cg, CG_IDLE)
    @(posedge clk);
    rst(0);
    $display("test fill done");
    end_sim();
  end
endmodule : pane_encoder_tb

// >>> bench/pane_sink.sv
// Purpose: Scrambler-side consumer model
// Assumes: Takes a group when valid and ready
// Notes:   Random stalls; hold stops all takes
`timescale 1ns/1ps
module pane_sink (
  input  wire logic clk,      // Clock
  input  wire logic reset,    // Reset
  input  wire logic hold,     // Stall all takes
  input  wire logic cg_valid, // Group offered
  output logic      cg_ready  // Group taken
);
  logic [15:0] lf_q;
  // Pseudo-random take pattern
  always_ff @(posedge clk) begin
    lf_q     <= reset ? 16'hACE1 : {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
    cg_ready <= !reset && !hold && (lf_q[1:0] != 2'h0);
  end
endmodule : pane_sink

// >>> verilog/pane_encoder.sv
// Purpose: PHY default addressing and 100 Mb 4B/5B transmit encoder
// Assumes: Internal MII nibbles synchronous to clk
// Notes:   Code-groups pass a FIFO before the scrambler stage
`timescale 1ns/1ps
// Overview of operation
// - Strap selects default addresses 0/1/2 or 1/2/3
// - Strap captured at reset release, then held
// - Port addresses overridable by address field
// - Addresses unchecked; configurer keeps them distinct
// - Nibbles arrive on internal MII from MAC
// - Management path address outputs for clause 22
// - Every data nibble becomes one code-group
// - Fixed data mapping for nibbles 0 to F
// - Non-data groups never sent as data
// - Idle sent after end pair until enable
// - Rising enable sends J then K
// - Falling enable sends T then R
module pane_encoder
  import pane_pkg::*;
(
  input  wire logic        clk,             // Transmit clock, 40 MHz
  input  wire logic        reset,           // Chip reset, active high
  input  wire logic        addr_sel_strap,  // Address-select strap level
  input  wire logic        port1_addr_wr,   // Port 1 address field write
  input  wire logic        port2_addr_wr,   // Port 2 address field write
  input  wire logic [4:0]  addr_wr_data,    // New address value
  output logic      [4:0]  vphy_addr,       // Virtual PHY address
  output logic      [4:0]  port1_addr,      // Port 1 address
  output logic      [4:0]  port2_addr,      // Port 2 address
  input  wire logic        mii_tx_en,       // MII transmit enable
  input  wire logic        mii_tx_er,       // MII transmit error
  input  wire logic [3:0]  mii_txd,         // MII transmit nibble
  output logic             mii_tx_ready,    // Encoder can take a group
  output logic      [4:0]  cg_data,         // Code-group to scrambler
  output logic             cg_valid,        // Code-group valid
  input  wire logic        cg_ready         // Scrambler takes group
);
  // --------------------------------------------------------------------------
  // Addressing
  // --------------------------------------------------------------------------
  logic        in_reset_q;
  logic        strap_q;
  logic [4:0]  p1_q;
  logic [4:0]  p2_q;
  wire         release_edge = in_reset_q && !reset;
  wire  [4:0]  p1_def = strap_q ? PORT1_ADDR_HIGH : PORT1_ADDR_LOW;
  wire  [4:0]  p2_def = strap_q ? PORT2_ADDR_HIGH : PORT2_ADDR_LOW;

  // Strap capture at reset release
  always_ff @(posedge clk) begin
    in_reset_q <= reset;
    if (release_edge) strap_q <= addr_sel_strap;
  end

  // Run-time address override, no uniqueness check
  always_ff @(posedge clk) begin
    if (reset) begin
      p1_q <= '0;
      p2_q <= '0;
    end else begin
      if (port1_addr_wr) p1_q <= addr_wr_data;
      if (port2_addr_wr) p2_q <= addr_wr_data;
    end
  end

  // Override flags select default or written value
  logic ov1_q;
  logic ov2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      ov1_q <= 1'b0;
      ov2_q <= 1'b0;
    end else begin
      if (port1_addr_wr) ov1_q <= 1'b1;
      if (port2_addr_wr) ov2_q <= 1'b1;
    end
  end

  // Addresses to the management path
  assign vphy_addr  = strap_q ? VPHY_ADDR_HIGH : VPHY_ADDR_LOW;
  assign port1_addr = ov1_q ? p1_q : p1_def;
  assign port2_addr = ov2_q ? p2_q : p2_def;

  // --------------------------------------------------------------------------
  // 4B/5B encoding
  // --------------------------------------------------------------------------
  pane_state_t st_q;
  pane_state_t st_d;
  logic [4:0]  grp_d;
  logic [4:0]  grp_q;
  logic        gv_q;
  logic        f_ready;
  logic [4:0]  data_cg;

  // Data nibble table; every nibble has a data group, never a control one
  always_comb begin
    unique case (mii_txd)
      4'h0:    data_cg = CG_D0;
      4'h1:    data_cg = CG_D1;
      4'h2:    data_cg = CG_D2;
      4'h3:    data_cg = CG_D3;
      4'h4:    data_cg = CG_D4;
      4'h5:    data_cg = CG_D5;
      4'h6:    data_cg = CG_D6;
      4'h7:    data_cg = CG_D7;
      4'h8:    data_cg = CG_D8;
      4'h9:    data_cg = CG_D9;
      4'hA:    data_cg = CG_DA;
      4'hB:    data_cg = CG_DB;
      4'hC:    data_cg = CG_DC;
      4'hD:    data_cg = CG_DD;
      4'hE:    data_cg = CG_DE;
      4'hF:    data_cg = CG_DF;
    endcase
  end

  // Stream sequencer
  always_comb begin
    st_d  = st_q;
    grp_d = CG_IDLE;
    unique case (st_q)
      PANE_IDLE: begin
        if (mii_tx_en) begin
          grp_d = CG_J;
          st_d  = PANE_SSD_K;
        end
      end
      PANE_SSD_K: begin
        grp_d = CG_K;
        st_d  = PANE_DATA;
      end
      PANE_DATA: begin
        if (mii_tx_en) begin
          grp_d = mii_tx_er ? CG_ERR : data_cg;
        end else begin
          grp_d = CG_T;
          st_d  = PANE_ESD_R;
        end
      end
      PANE_ESD_R: begin
        grp_d = CG_R;
        st_d  = PANE_IDLE;
      end
      default: begin
        st_d = PANE_IDLE;
      end
    endcase
  end

  assign mii_tx_ready = f_ready;

  // One group per accepted clock, idle during reset
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q  <= PANE_IDLE;
      grp_q <= CG_IDLE;
      gv_q  <= 1'b0;
    end else if (f_ready) begin
      st_q  <= st_d;
      grp_q <= grp_d;
      gv_q  <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Output buffer toward the scrambler
  // --------------------------------------------------------------------------
  logic [4:0] f_data;
  logic       f_valid;
  logic [4:0] ob_data_q;
  logic       ob_valid_q;
  wire        ob_free = !ob_valid_q || cg_ready;  // Stage empty or being emptied
  wire        ob_load = f_valid && ob_free;       // Move FIFO head into the stage

  pane_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (gv_q && f_ready),
    .in_ready  (f_ready),
    .in_data   (grp_q),
    .out_valid (f_valid),
    .out_ready (ob_free),
    .out_data  (f_data)
  );

  // Registered output stage; keeps a stalled group, idle when empty
  always_ff @(posedge clk) begin
    if (reset) begin
      ob_data_q  <= CG_IDLE;
      ob_valid_q <= 1'b0;
    end else if (ob_load) begin
      ob_data_q  <= f_data;
      ob_valid_q <= 1'b1;
    end else if (cg_ready) begin
      ob_data_q  <= CG_IDLE;
      ob_valid_q <= 1'b0;
    end
  end

  // Scrambler side comes straight from flip-flops
  assign cg_valid = ob_valid_q;
  assign cg_data  = ob_data_q;
endmodule : pane_encoder

// >>> verilog/pane_fifo.sv
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Depth a power of two
// Notes:   Read data come from a register
`timescale 1ns/1ps
module pane_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,      // Clock
  input  wire logic             reset,    // Sync reset
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  output logic                  out_valid,// Output holds a word
  input  wire logic             out_ready,// Consumer takes word
  output logic      [WIDTH-1:0] out_data  // Registered read data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             ov_q;
  logic [WIDTH-1:0] od_q;
  wire              empty = (wr_q == rd_q);
  wire              full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  wire              push  = in_valid && !full;
  wire              load  = !empty && (!ov_q || out_ready);

  // --------------------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------------------
  assign in_ready  = !full;
  assign out_valid = ov_q;
  assign out_data  = od_q;

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers and output register
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (load) begin
        od_q <= mem_q[rd_q[AW-1:0]];
        rd_q <= rd_q + 1'b1;
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
    end
  end
endmodule : pane_fifo

// >>> verilog/pane_pkg.sv
// Purpose: Shared constants for PHY addressing and the 4B/5B transmit encoder
// Assumes: One clock, synchronous active-high reset
// Notes:   Code-groups are five bits, nibbles four bits
package pane_pkg;
  // --------------------------------------------------------------------------
  // Management addressing
  // --------------------------------------------------------------------------
  localparam int           ADDR_W          = 5;
  localparam logic [4:0]   VPHY_ADDR_LOW   = 5'h00;
  localparam logic [4:0]   PORT1_ADDR_LOW  = 5'h01;
  localparam logic [4:0]   PORT2_ADDR_LOW  = 5'h02;
  localparam logic [4:0]   VPHY_ADDR_HIGH  = 5'h01;
  localparam logic [4:0]   PORT1_ADDR_HIGH = 5'h02;
  localparam logic [4:0]   PORT2_ADDR_HIGH = 5'h03;

  // --------------------------------------------------------------------------
  // Code-groups
  // --------------------------------------------------------------------------
  localparam logic [4:0]   CG_IDLE  = 5'h1F;
  localparam logic [4:0]   CG_J     = 5'h18;
  localparam logic [4:0]   CG_K     = 5'h11;
  localparam logic [4:0]   CG_T     = 5'h0D;
  localparam logic [4:0]   CG_R     = 5'h07;
  localparam logic [4:0]   CG_ERR   = 5'h04;
  localparam logic [4:0]   CG_D0    = 5'h1E;
  localparam logic [4:0]   CG_D1    = 5'h09;
  localparam logic [4:0]   CG_D2    = 5'h14;
  localparam logic [4:0]   CG_D3    = 5'h15;
  localparam logic [4:0]   CG_D4    = 5'h0A;
  localparam logic [4:0]   CG_D5    = 5'h0B;
  localparam logic [4:0]   CG_D6    = 5'h0E;
  localparam logic [4:0]   CG_D7    = 5'h0F;
  localparam logic [4:0]   CG_D8    = 5'h12;
  localparam logic [4:0]   CG_D9    = 5'h13;
  localparam logic [4:0]   CG_DA    = 5'h16;
  localparam logic [4:0]   CG_DB    = 5'h17;
  localparam logic [4:0]   CG_DC    = 5'h1A;
  localparam logic [4:0]   CG_DD    = 5'h1B;
  localparam logic [4:0]   CG_DE    = 5'h1C;
  localparam logic [4:0]   CG_DF    = 5'h1D;

  // --------------------------------------------------------------------------
  // FIFO and encoder state
  // --------------------------------------------------------------------------
  localparam int           FIFO_DEPTH = 32;
  localparam int           FIFO_WIDTH = 5;

  typedef enum logic [2:0] {
    PANE_IDLE, PANE_SSD_K, PANE_DATA, PANE_ESD_R
  } pane_state_t;
endpackage : pane_pkg
